// ### sim/synth_ctrl_checker.sv
// Port checker for the clock synthesizer control block.
// Assumes it is bound to the top module's ports.
`timescale 1ns/1ps
module synth_ctrl_checker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [15:0] io_addr_i,
    input wire logic io_wr_i,
    input wire logic io_rd_i,
    input wire logic [7:0] io_wdata_i,
    input wire logic [7:0] io_rdata_o,
    input wire logic [6:0] numerator_value_o,
    input wire logic [4:0] denominator_value_o,
    input wire logic post_scale_o,
    input wire logic vco_double_o,
    input wire logic [5:0] memclk_mult_o,
    input wire logic pixel_from_memclk_o,
    input wire logic memclk_halved_o,
    input wire logic [1:0] pixel_clock_select_o
);
// ----------------
// Properties
// ----------------
logic [7:0] idx;
logic dw;
assign dw = io_addr_i == 16'h03C5;
always_ff @(posedge clk_i) begin
    if (rst_i) begin
        idx <= 8'h00;
    end else if (io_wr_i && io_addr_i == 16'h03C4) begin
        idx <= io_wdata_i;
    end
end
default clocking @(posedge clk_i);
endclocking
default disable iff (rst_i);
a_vco_post: assert property (vco_double_o == post_scale_o)
    else $error("vco flag differs from post-scaler");
a_halved_src: assert property (memclk_halved_o
    |-> pixel_from_memclk_o)
    else $error("halved without memory clock source");
a_misc_sel: assert property (io_wr_i && io_addr_i == 16'h03C2
    |-> ##2 pixel_clock_select_o == $past(io_wdata_i[3:2], 2))
    else $error("clock select not taken");
a_memclk_wr: assert property (io_wr_i && dw && idx == 8'h1F |-> ##2
    memclk_mult_o == $past(io_wdata_i[5:0], 2)
    && pixel_from_memclk_o == $past(io_wdata_i[6], 2))
    else $error("memory clock word not taken");
a_div_rsvd: assert property (io_rd_i && dw && idx >= 8'h1B
    && idx <= 8'h1E |=> io_rdata_o[7:6] == 2'h0)
    else $error("divider reserved bits nonzero");
a_mem_bit7: assert property (io_rd_i && dw && idx == 8'h1F
    |=> !io_rdata_o[7]) else $error("memclk bit 7 nonzero");
a_reset_load: assert property ($fell(rst_i) |=>
    numerator_value_o == 7'h66 && denominator_value_o == 5'h1D
    && post_scale_o && memclk_mult_o == 6'h18 && !pixel_from_memclk_o)
    else $error("reset control words wrong");
a_ctl_hold: assert property (!$past(io_wr_i, 2) && !$past(rst_i, 2)
    && !$past(rst_i) |-> $stable(numerator_value_o)
    && $stable(denominator_value_o)) else $error("control word moved");
c_misc: cover property (io_wr_i && io_addr_i == 16'h03C2);
c_src: cover property (pixel_from_memclk_o);
c_halved: cover property (memclk_halved_o);
endmodule

bind video_memory_clock_synth_ctrl synth_ctrl_checker chk (.clk_i, .rst_i,
    .io_addr_i, .io_wr_i, .io_rd_i, .io_wdata_i, .io_rdata_o,
    .numerator_value_o, .denominator_value_o, .post_scale_o, .vco_double_o,
    .memclk_mult_o, .pixel_from_memclk_o, .memclk_halved_o,
    .pixel_clock_select_o);

// ### sim/video_memory_clock_synth_ctrl_tb.sv
// Self-checking bench for the clock synthesizer control block.
// Assumes the checker file is compiled beside the design.
`timescale 1ns/1ps
module video_memory_clock_synth_ctrl_tb;
// ----------------
// Bench
// ----------------
logic clk_i = 1'b0;
logic rst_i = 1'b1;
logic [15:0] io_addr_i = 16'h0000;
logic io_wr_i = 1'b0;
logic io_rd_i = 1'b0;
logic [7:0] io_wdata_i = 8'h00;
logic [7:0] io_rdata_o;
logic [6:0] numerator_value_o;
logic [4:0] denominator_value_o;
logic post_scale_o;
logic vco_double_o;
logic [5:0] memclk_mult_o;
logic pixel_from_memclk_o;
logic memclk_halved_o;
logic [1:0] pixel_clock_select_o;
int err_count = 0;
int checked = 0;
logic [7:0] num_rst [4] = '{8'h66, 8'h5B, 8'h45, 8'h7E};
logic [7:0] div_rst [4] = '{8'h3B, 8'h2F, 8'h30, 8'h33};
video_memory_clock_synth_ctrl dut (.clk_i, .rst_i, .io_addr_i, .io_wr_i,
    .io_rd_i, .io_wdata_i, .io_rdata_o, .numerator_value_o,
    .denominator_value_o, .post_scale_o, .vco_double_o, .memclk_mult_o,
    .pixel_from_memclk_o, .memclk_halved_o, .pixel_clock_select_o);
initial begin
    forever #5 clk_i = ~clk_i;
end
task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
        err_count++;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
endtask
task automatic step(input logic r, input logic [15:0] a,
                    input logic [7:0] d);
    @(posedge clk_i);
    #1;
    io_addr_i = a;
    io_wdata_i = d;
    io_wr_i = !r;
    io_rd_i = r;
    @(posedge clk_i);
    #1;
    io_wr_i = 1'b0;
    io_rd_i = 1'b0;
endtask
task automatic wi(input logic [7:0] i, input logic [7:0] d);
    step(1'b0, 16'h03C4, i);
    step(1'b0, 16'h03C5, d);
endtask
task automatic rp(input logic [15:0] a, input logic [7:0] exp);
    step(1'b1, a, 8'h00);
    chk(io_rdata_o, exp);
endtask
task automatic ri(input logic [7:0] i, input logic [7:0] exp);
    step(1'b0, 16'h03C4, i);
    rp(16'h03C5, exp);
endtask
task automatic outs(input logic [7:0] n, input logic [7:0] dv);
    repeat (2) @(posedge clk_i);
    #1;
    chk({1'b0, numerator_value_o}, n);
    chk({3'h0, denominator_value_o}, {3'h0, dv[5:1]});
    chk({6'h00, post_scale_o, vco_double_o}, {6'h00, dv[0], dv[0]});
endtask
task automatic print_verdict;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
        $display("verification passed");
    end else begin
        $display("verification failed");
    end
    $finish;
endtask
initial begin
    #50000;
    err_count++;
    print_verdict;
end
initial begin
    repeat (16) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    for (int i = 0; i < 4; i++) begin
        ri(8'h0B + i[7:0], num_rst[i]);
        ri(8'h1B + i[7:0], div_rst[i]);
    end
    ri(8'h1F, 8'h18);
    outs(8'h66, 8'h3B);
    chk({2'h0, memclk_mult_o}, 8'h18);
    chk({6'h00, pixel_from_memclk_o, memclk_halved_o}, 8'h00);
    $display("test reset values done");
    for (int i = 0; i < 4; i++) begin
        step(1'b0, 16'h03C2, {4'h0, i[1:0], 2'h0});
        outs(num_rst[i], div_rst[i]);
        chk({6'h00, pixel_clock_select_o}, {6'h00, i[1:0]});
    end
    $display("test clock select done");
    wi(8'h0C, 8'hFF);
    wi(8'h1C, 8'hFF);
    ri(8'h0C, 8'h7F);
    ri(8'h1C, 8'h3F);
    step(1'b0, 16'h03C2, 8'h04);
    outs(8'h7F, 8'h3F);
    rp(16'h03CC, 8'h04);
    $display("test divider fields done");
    wi(8'h1F, 8'hE6);
    ri(8'h1F, 8'h66);
    chk({2'h0, memclk_mult_o}, 8'h26);
    chk({6'h00, pixel_from_memclk_o, memclk_halved_o}, 8'h03);
    wi(8'h1E, 8'h32);
    outs(8'h7F, 8'h3F);
    chk({6'h00, pixel_from_memclk_o, memclk_halved_o}, 8'h02);
    wi(8'h1F, 8'h15);
    outs(8'h7F, 8'h3F);
    chk({2'h0, memclk_mult_o, memclk_halved_o, pixel_from_memclk_o},
        8'h54);
    $display("test memory clock source done");
    ri(8'h20, 8'h00);
    wi(8'h20, 8'hA5);
    ri(8'h20, 8'h00);
    rp(16'h03C4, 8'h20);
    @(posedge clk_i);
    #1;
    chk(io_rdata_o, 8'h00);
    rst_i = 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    ri(8'h1C, 8'h2F);
    ri(8'h1F, 8'h18);
    rp(16'h03CC, 8'h00);
    $display("test unmapped and second reset done");
    print_verdict;
end
endmodule

// ### verilog/clk_synth_cfg.svh
// Offsets, field positions, reset values for the clock synthesizer control.
// Assumes inclusion by bare name from design files.
`ifndef CLK_SYNTH_CFG_SVH
`define CLK_SYNTH_CFG_SVH

`define IO_INDEX_PORT 16'h03C4
`define IO_DATA_PORT 16'h03C5
`define IO_MISC_WR_PORT 16'h03C2
`define IO_MISC_RD_PORT 16'h03CC

`define IDX_NUMERATOR_BASE 8'h0B
`define IDX_DIVIDER_BASE 8'h1B
`define IDX_MEMCLK_SOURCE 8'h1F

`define NUM0_RESET 8'h66
`define NUM1_RESET 8'h5B
`define NUM2_RESET 8'h45
`define NUM3_RESET 8'h7E
`define DIV0_RESET 8'h3B
`define DIV1_RESET 8'h2F
`define DIV2_RESET 8'h30
`define DIV3_RESET 8'h33
`define MEMCLK_RESET 8'h18
`define MISC_RESET 8'h00

`define NUM_MASK 8'h7F
`define DIV_MASK 8'h3F
`define MEMCLK_MASK 8'h7F
`define SRC_SEL_BIT 6
`define MISC_SEL_LSB 2
`define POST_BIT 0

`endif

// ### verilog/clk_synth_pkg.sv
// Types shared by the clock synthesizer control files.
// Assumes no other package.
package clk_synth_pkg;
    typedef logic [7:0] reg_byte_t;
    typedef logic [1:0] clk_sel_t;
    typedef logic [6:0] numerator_t;
    typedef logic [4:0] denominator_t;
    typedef logic [5:0] memclk_mult_t;
endpackage

// ### verilog/pixel_clock_selector.sv
// Combinational pick of the active pixel clock settings.
// Assumes the register bytes arrive already masked.
`timescale 1ns/1ps
module pixel_clock_selector (
    input wire clk_synth_pkg::clk_sel_t sel_i,
    input wire logic [31:0] numerators_i,
    input wire logic [31:0] dividers_i,
    output clk_synth_pkg::numerator_t numerator_value_o,
    output clk_synth_pkg::denominator_t denominator_value_o,
    output logic post_scale_o
);
    // -------------------------------------------------------------
    // Selection
    // -------------------------------------------------------------
    clk_synth_pkg::reg_byte_t num_byte;
    clk_synth_pkg::reg_byte_t div_byte;

    always_comb begin
        num_byte = numerators_i[sel_i*8 +: 8];
        div_byte = dividers_i[sel_i*8 +: 8];
        numerator_value_o = num_byte[6:0]; // [R2]
        denominator_value_o = div_byte[5:1]; // [R8]
        post_scale_o = div_byte[0]; // [R9]
    end
endmodule

// ### verilog/video_memory_clock_synth_ctrl.sv
// Register file and control words for the pixel and memory synthesizers.
// Assumes host I/O strobes are one-cycle and synchronous to clk_i.
// What this block does
// [R1] Pixel clock = reference times numerator over denominator times (post+1).
// [R2] Numerator per pixel clock comes from its register's low seven bits.
// [R3] Misc output register bits 3:2 choose the active pixel clock.
// [R4] Reset: clock 0 numerator 66h, divider 3Bh.
// [R5] Reset: clock 1 numerator 5Bh, divider 2Fh.
// [R6] Reset: clock 2 numerator 45h, divider 30h.
// [R7] Reset: clock 3 numerator 7Eh, divider 33h.
// [R8] Denominator is divider register bits five to one.
// [R9] Divider bit zero is the post-scaler: divide by one or two.
// [R10] Post-scaler set means oscillator runs at twice reference.
// [R11] Source bit 0 means pixel clock from its synthesizer; resets 0.
// [R12] Source bit 1 with clock-3 post 0 gives memory clock undivided.
// [R13] Source bit 1 with clock-3 post 1 gives memory clock halved.
// [R14] Memory clock = six-bit multiplier times reference over eight.
// [R15] Software writes only 21 to 38 into the multiplier.
// [R16] Multiplier resets to 24 decimal, 18h.
// [R17] Only firmware programs the memory clock and source register.
// [R18] Reserved divider bits 7:6 and memclk bit 7 read zero.
`timescale 1ns/1ps
`include "clk_synth_cfg.svh"
module video_memory_clock_synth_ctrl #(
    parameter int NUM_CLOCKS = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [15:0] io_addr_i,
    input wire logic io_wr_i,
    input wire logic io_rd_i,
    input wire logic [7:0] io_wdata_i,
    output logic [7:0] io_rdata_o,
    output logic [6:0] numerator_value_o,
    output logic [4:0] denominator_value_o,
    output logic post_scale_o,
    output logic vco_double_o,
    output logic [5:0] memclk_mult_o,
    output logic pixel_from_memclk_o,
    output logic memclk_halved_o,
    output logic [1:0] pixel_clock_select_o
);
    // -------------------------------------------------------------
    // Elaboration check
    // -------------------------------------------------------------
    if (NUM_CLOCKS != 4) begin : g_bad_count
        $error("NUM_CLOCKS must be 4");
    end

    // -------------------------------------------------------------
    // Decode helpers
    // -------------------------------------------------------------
    function automatic logic in_range(input logic [7:0] idx,
                                      input logic [7:0] base);
        logic [7:0] d;
        d = idx - base;
        in_range = (idx >= base) && (d < 8'h04);
    endfunction

    function automatic logic [1:0] index_slot(input logic [7:0] idx,
                                              input logic [7:0] base);
        logic [7:0] d;
        d = idx - base;
        index_slot = d[1:0];
    endfunction

    localparam logic [31:0] NUM_RESETS = {`NUM3_RESET, `NUM2_RESET,
                                          `NUM1_RESET, `NUM0_RESET};
    localparam logic [31:0] DIV_RESETS = {`DIV3_RESET, `DIV2_RESET,
                                          `DIV1_RESET, `DIV0_RESET};

    // -------------------------------------------------------------
    // Register state
    // -------------------------------------------------------------
    clk_synth_pkg::reg_byte_t index_reg;
    clk_synth_pkg::reg_byte_t misc_reg;
    clk_synth_pkg::reg_byte_t memclk_source_register;
    logic [31:0] numerators;
    logic [31:0] dividers;
    clk_synth_pkg::reg_byte_t next_index_reg;
    clk_synth_pkg::reg_byte_t next_misc_reg;
    clk_synth_pkg::reg_byte_t next_memclk_source_register;
    logic [31:0] next_numerators;
    logic [31:0] next_dividers;
    logic data_wr;
    logic [1:0] num_slot;
    logic [1:0] div_slot;

    always_comb begin
        data_wr = io_wr_i && (io_addr_i == `IO_DATA_PORT);
        num_slot = index_slot(index_reg, `IDX_NUMERATOR_BASE);
        div_slot = index_slot(index_reg, `IDX_DIVIDER_BASE);
        next_index_reg = index_reg;
        next_misc_reg = misc_reg;
        next_memclk_source_register = memclk_source_register;
        next_numerators = numerators;
        next_dividers = dividers;
        if (io_wr_i && (io_addr_i == `IO_INDEX_PORT)) begin
            next_index_reg = io_wdata_i;
        end
        if (io_wr_i && (io_addr_i == `IO_MISC_WR_PORT)) begin
            next_misc_reg = io_wdata_i;
        end
        if (data_wr && index_reg == `IDX_MEMCLK_SOURCE) begin
            next_memclk_source_register = io_wdata_i & `MEMCLK_MASK; // [R18]
        end
        if (data_wr && in_range(index_reg, `IDX_NUMERATOR_BASE)) begin
            next_numerators[num_slot*8 +: 8] = io_wdata_i & `NUM_MASK; // [R2]
        end
        if (data_wr && in_range(index_reg, `IDX_DIVIDER_BASE)) begin
            next_dividers[div_slot*8 +: 8] = io_wdata_i & `DIV_MASK; // [R18]
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            index_reg <= 8'h00;
            misc_reg <= `MISC_RESET;
            memclk_source_register <= `MEMCLK_RESET; // [R16] [R11]
            numerators <= NUM_RESETS; // [R4] [R5] [R6] [R7]
            dividers <= DIV_RESETS; // [R4] [R5] [R6] [R7]
        end else begin
            index_reg <= next_index_reg;
            misc_reg <= next_misc_reg;
            memclk_source_register <= next_memclk_source_register;
            numerators <= next_numerators;
            dividers <= next_dividers;
        end
    end

    // -------------------------------------------------------------
    // Read path
    // -------------------------------------------------------------
    logic [7:0] next_io_rdata;

    always_comb begin
        next_io_rdata = 8'h00;
        if (io_rd_i) begin
            if (io_addr_i == `IO_INDEX_PORT) begin
                next_io_rdata = index_reg;
            end else if (io_addr_i == `IO_MISC_RD_PORT) begin
                next_io_rdata = misc_reg;
            end else if (io_addr_i == `IO_DATA_PORT) begin
                if (index_reg == `IDX_MEMCLK_SOURCE) begin
                    next_io_rdata = memclk_source_register;
                end else if (in_range(index_reg, `IDX_NUMERATOR_BASE)) begin
                    next_io_rdata = numerators[num_slot*8 +: 8];
                end else if (in_range(index_reg, `IDX_DIVIDER_BASE)) begin
                    next_io_rdata = dividers[div_slot*8 +: 8];
                end
            end
        end
    end

    // -------------------------------------------------------------
    // Synthesizer control words
    // -------------------------------------------------------------
    clk_synth_pkg::numerator_t sel_num;
    clk_synth_pkg::denominator_t sel_den;
    logic sel_post;
    clk_synth_pkg::clk_sel_t active_sel;

    assign active_sel = misc_reg[`MISC_SEL_LSB +: 2]; // [R3]

    pixel_clock_selector u_sel (
        .sel_i(active_sel), // [R3]
        .numerators_i(numerators),
        .dividers_i(dividers),
        .numerator_value_o(sel_num),
        .denominator_value_o(sel_den),
        .post_scale_o(sel_post)
    );

    // -------------------------------------------------------------
    // Output next values
    // -------------------------------------------------------------
    logic next_from_memclk;
    logic next_halved;
    clk_synth_pkg::numerator_t next_numerator_value;
    clk_synth_pkg::denominator_t next_denominator_value;
    logic next_post_scale;
    logic next_vco_double;
    clk_synth_pkg::memclk_mult_t next_memclk_mult;
    clk_synth_pkg::clk_sel_t next_pixel_clock_select;

    always_comb begin
        next_from_memclk = memclk_source_register[`SRC_SEL_BIT]; // [R11]
        // Clock-3 post-scaler picks undivided or halved memory clock
        next_halved = next_from_memclk && dividers[24 + `POST_BIT]; // [R12] [R13]
        next_numerator_value = sel_num; // [R1] [R2]
        next_denominator_value = sel_den; // [R1] [R8]
        next_post_scale = sel_post; // [R1] [R9]
        next_vco_double = sel_post; // [R10]
        next_memclk_mult = memclk_source_register[5:0]; // [R14]
        next_pixel_clock_select = active_sel; // [R3]
    end

    // -------------------------------------------------------------
    // Output registers
    // -------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            io_rdata_o <= 8'h00;
            numerator_value_o <= 7'h00;
            denominator_value_o <= 5'h00;
            post_scale_o <= 1'b0;
            vco_double_o <= 1'b0;
            memclk_mult_o <= 6'h00;
            pixel_from_memclk_o <= 1'b0;
            memclk_halved_o <= 1'b0;
            pixel_clock_select_o <= 2'h0;
        end else begin
            io_rdata_o <= next_io_rdata;
            numerator_value_o <= next_numerator_value;
            denominator_value_o <= next_denominator_value;
            post_scale_o <= next_post_scale;
            vco_double_o <= next_vco_double;
            memclk_mult_o <= next_memclk_mult;
            pixel_from_memclk_o <= next_from_memclk;
            memclk_halved_o <= next_halved;
            pixel_clock_select_o <= next_pixel_clock_select;
        end
    end
endmodule
